/* File: verilog/mode_ctl_consts.vh */
/*
  constants for the gate driver operating-mode supervisor: frame layout,
  register addresses, mode codes, status bits and timing counts.
  assumes a 50 MHz core clock and a 16-bit spi frame.
*/
// How it works
// - low battery sets status bits five and one
// - low logic supply sets bit one only
// - pumps off when battery low in reduced
// - sleep on inhibit low or battery below 3 V
// - first config write enters configuration, error low
// - config timer expiry enters configuration lock
// - safe-off error pin shows fault presence
// - normal only after signature before timeout
// - leaving lock needs sleep: inhibit low or battery below 3 V
`ifndef MODE_CTL_CONSTS_VH
`define MODE_CTL_CONSTS_VH
`define FRAME_BITS        16
`define ADDR_SUPPLY_RED   7'h43
`define ADDR_OUTSIDE      7'h45
`define ADDR_MODE_STAT    7'h46
`define ADDR_LINK_FAULT   7'h4a
`define ADDR_SIGNATURE    7'h3f
`define ADDR_CFG_LAST     7'h3e
`define BIT_VS_RED        5
`define BIT_REDUCED       1
`define BIT_SIG_DONE      3
`define BIT_CRC_ERR       0
`define BIT_LOCK_ERR      1
`define MODE_SLEEP        3'h0
`define MODE_IDLE         3'h1
`define MODE_CONFIG       3'h2
`define MODE_LOCK         3'h3
`define MODE_NORMAL       3'h4
`define MODE_REDUCED      3'h5
`define MODE_SAFE_OFF     3'h6
`define MODE_ERROR        3'h7
`define SIG_VALUE         8'h5a
`define CLK_MHZ           50
`define SIG_CHECK_NS      1200
`define SIG_CHECK_CYC     ((`SIG_CHECK_NS * `CLK_MHZ) / 1000)
`define CFG_TIMEOUT_CYC   32'd5000000
`endif

/* File: verilog/gate_driver_mode_control.v */
/*
  operating-mode supervisor with spi slave: holds mode, reduced-operation
  status, signature check and configuration timer.
  assumes supply comparators and fault detectors are external inputs; spi
  frame is 16 bits: r/w, 7-bit address, 5 data bits, 3 crc bits (msb first).
*/
`include "mode_ctl_consts.vh"
`default_nettype none
module gate_driver_mode_control #(
  parameter [31:0] CFG_TIMEOUT = `CFG_TIMEOUT_CYC
) (
  input  wire       clk_in,
  input  wire       reset_n_in,
  input  wire       inhibit_n_in,
  input  wire       driver_enable_in,
  input  wire       safe_off_n_in,
  input  wire       battery_reduced_in,
  input  wire       battery_below_3v_in,
  input  wire       logic_supply_reduced_in,
  input  wire       fault_in,
  input  wire [4:0] outside_faults_in,
  input  wire       spi_cs_n_in,
  input  wire       spi_sck_in,
  input  wire       spi_mosi_in,
  output reg        spi_miso_out,
  output reg        spi_miso_oe_n_out,
  output reg        error_n_out,
  output reg        outputs_enable_out,
  output reg        passive_clamp_out,
  output reg        sense_amplifier_on_out,
  output reg        pumps_on_out,
  output reg  [2:0] mode_out
);
  reg [1:0] s_inh, s_ena, s_safe_off_n, s_vsr, s_vs3, s_vcr, s_flt, s_cs, s_sck, s_mosi;
  reg [4:0] s_ext0, s_ext1;
  reg       sck_d;
  reg [2:0] mode;
  reg [15:0] shift;
  reg [15:0] resp;
  reg [4:0]  bitcnt;
  reg [15:0] supply_reduced_status;
  reg [4:0]  link_and_setup_faults;
  reg [31:0] cfg_timer;
  reg [7:0]  sig_cnt;
  reg [7:0]  sig_byte;
  reg        sig_pending;
  reg        sig_done;

  function [2:0] crc3;
    input [12:0] d;
    integer i;
    reg [2:0] c;
    begin
      c = 3'h7;
      for (i = 12; i >= 0; i = i - 1) begin
        c = {c[1:0], 1'b0} ^ ((c[2] ^ d[i]) ? 3'h3 : 3'h0);
      end
      crc3 = c;
    end
  endfunction

  function [4:0] reg_read;
    input [6:0] a;
    begin
      case (a)
        // five-bit data field: bit five rides in the top slot so both causes show
        `ADDR_SUPPLY_RED: reg_read = {supply_reduced_status[`BIT_VS_RED],
                                      supply_reduced_status[3:0]};
        `ADDR_OUTSIDE:    reg_read = s_ext1;
        `ADDR_MODE_STAT:  reg_read = {sig_done, 1'b0, mode};
        `ADDR_LINK_FAULT: reg_read = link_and_setup_faults;
        default:          reg_read = 5'h00;
      endcase
    end
  endfunction

  wire sck_rise = s_sck[1] & ~sck_d;
  wire frame_end = (bitcnt == 5'd16);
  wire crc_ok = (crc3(shift[15:3]) == shift[2:0]);
  wire is_write = shift[15];
  wire [6:0] addr = shift[14:8];
  wire spi_live = s_inh[1] && mode != `MODE_SLEEP && mode != `MODE_REDUCED;
  wire sleep_cond = ~s_inh[1] | s_vs3[1];
  wire reduced_cond = s_vsr[1] | s_vcr[1];
  wire [31:0] sig_wait = `SIG_CHECK_CYC - 1;
  // only five data bits reach the signature, so the low five are matched
  localparam [7:0] SIG_FULL = `SIG_VALUE;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_inh <= 2'b00; s_ena <= 2'b00; s_safe_off_n <= 2'b00; s_vsr <= 2'b00;
      s_vs3 <= 2'b00; s_vcr <= 2'b00; s_flt <= 2'b00; s_cs <= 2'b11;
      s_sck <= 2'b00; s_mosi <= 2'b00; s_ext0 <= 5'h00; s_ext1 <= 5'h00;
      sck_d <= 1'b0;
    end else begin
      s_inh <= {s_inh[0], inhibit_n_in};
      s_ena <= {s_ena[0], driver_enable_in};
      s_safe_off_n <= {s_safe_off_n[0], safe_off_n_in};
      s_vsr <= {s_vsr[0], battery_reduced_in};
      s_vs3 <= {s_vs3[0], battery_below_3v_in};
      s_vcr <= {s_vcr[0], logic_supply_reduced_in};
      s_flt <= {s_flt[0], fault_in};
      s_cs <= {s_cs[0], spi_cs_n_in};
      s_sck <= {s_sck[0], spi_sck_in};
      s_mosi <= {s_mosi[0], spi_mosi_in};
      s_ext0 <= outside_faults_in;
      s_ext1 <= s_ext0;
      sck_d <= s_sck[1];
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode <= `MODE_SLEEP;
      shift <= 16'h0000;
      resp <= 16'h0000;
      bitcnt <= 5'd0;
      supply_reduced_status <= 16'h0000;
      link_and_setup_faults <= 5'h00;
      cfg_timer <= 32'd0;
      sig_cnt <= 8'd0;
      sig_byte <= 8'h00;
      sig_pending <= 1'b0;
      sig_done <= 1'b0;
    end else if (sleep_cond) begin
      mode <= `MODE_SLEEP;
      supply_reduced_status <= 16'h0000;
      link_and_setup_faults <= 5'h00;
      cfg_timer <= 32'd0;
      sig_pending <= 1'b0;
      sig_done <= 1'b0;
      bitcnt <= 5'd0;
    end else begin
      // reduced operation records cause; bit five only for battery
      if (s_vsr[1]) begin
        supply_reduced_status[`BIT_VS_RED] <= 1'b1;
        supply_reduced_status[`BIT_REDUCED] <= 1'b1;
      end
      if (s_vcr[1]) begin
        supply_reduced_status[`BIT_REDUCED] <= 1'b1;
      end
      if (s_cs[1]) begin
        bitcnt <= 5'd0;
      end else if (sck_rise && spi_live && !frame_end) begin
        shift <= {shift[14:0], s_mosi[1]};
        resp <= {resp[14:0], 1'b0};
        bitcnt <= bitcnt + 5'd1;
      end
      if (sig_pending) begin
        // signature compare takes a fixed settle time
        if (sig_cnt == 8'd0) begin
          sig_pending <= 1'b0;
          sig_done <= 1'b1;
          if (sig_byte == {3'b000, SIG_FULL[4:0]} && mode == `MODE_CONFIG) begin
            mode <= `MODE_NORMAL;
          end
        end else begin
          sig_cnt <= sig_cnt - 8'd1;
        end
      end
      case (mode)
        `MODE_SLEEP: mode <= `MODE_IDLE;
        `MODE_REDUCED: begin
          if (!reduced_cond) begin
            mode <= `MODE_CONFIG;
            cfg_timer <= 32'd0;
          end
        end
        `MODE_CONFIG: begin
          if (reduced_cond) begin
            mode <= `MODE_REDUCED;
          end else if (cfg_timer >= CFG_TIMEOUT - 32'd1) begin
            mode <= `MODE_LOCK;
          end else begin
            cfg_timer <= cfg_timer + 32'd1;
          end
        end
        `MODE_LOCK: mode <= `MODE_LOCK;
        `MODE_NORMAL, `MODE_SAFE_OFF, `MODE_ERROR: begin
          if (reduced_cond) mode <= `MODE_REDUCED;
          else if (!s_safe_off_n[1]) mode <= `MODE_SAFE_OFF;
          else if (s_flt[1]) mode <= `MODE_ERROR;
          else mode <= `MODE_NORMAL;
        end
        default: begin
          if (reduced_cond) mode <= `MODE_REDUCED;
        end
      endcase
      if (s_cs[1] && frame_end) begin
        if (!crc_ok) begin
          link_and_setup_faults[`BIT_CRC_ERR] <= 1'b1;
        end else if (is_write && mode == `MODE_LOCK) begin
          link_and_setup_faults[`BIT_LOCK_ERR] <= 1'b1;
        end else if (is_write && addr <= `ADDR_CFG_LAST && mode == `MODE_IDLE) begin
          mode <= `MODE_CONFIG;
          cfg_timer <= 32'd0;
        end else if (is_write && addr == `ADDR_SIGNATURE && mode == `MODE_CONFIG) begin
          sig_byte <= {3'b000, shift[7:3]};
          sig_pending <= 1'b1;
          sig_cnt <= sig_wait[7:0];
        end
        resp <= {shift[15:8], (is_write ? shift[7:3] : reg_read(addr)),
                 crc3({shift[15:8], (is_write ? shift[7:3] : reg_read(addr))})};
      end
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      spi_miso_out <= 1'b0;
      spi_miso_oe_n_out <= 1'b1;
      error_n_out <= 1'b0;
      outputs_enable_out <= 1'b0;
      passive_clamp_out <= 1'b1;
      sense_amplifier_on_out <= 1'b0;
      pumps_on_out <= 1'b0;
      mode_out <= `MODE_SLEEP;
    end else begin
      spi_miso_out <= resp[15];
      spi_miso_oe_n_out <= s_cs[1] | ~spi_live;
      mode_out <= mode;
      outputs_enable_out <= (mode == `MODE_NORMAL) && s_ena[1];
      passive_clamp_out <= (mode == `MODE_SLEEP) || (mode == `MODE_REDUCED);
      sense_amplifier_on_out <= (mode != `MODE_SLEEP) && (mode != `MODE_REDUCED);
      pumps_on_out <= (mode != `MODE_SLEEP) && !(mode == `MODE_REDUCED && s_vsr[1]);
      case (mode)
        `MODE_IDLE, `MODE_NORMAL: error_n_out <= 1'b1;
        `MODE_CONFIG: error_n_out <= 1'b0;
        `MODE_LOCK: error_n_out <= 1'b0;
        `MODE_SAFE_OFF: error_n_out <= ~s_flt[1];
        default: error_n_out <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: test/mode_ctl_properties.sv */
/* mode supervisor assertions on the top module ports
   assumes mode codes from mode_ctl_consts.vh */
`include "mode_ctl_consts.vh"
`default_nettype none
module mode_ctl_chk (
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic       inhibit_n_in,
  input wire logic       battery_below_3v_in,
  input wire logic       battery_reduced_in,
  input wire logic       fault_in,
  input wire logic       spi_cs_n_in,
  input wire logic       error_n_out,
  input wire logic       outputs_enable_out,
  input wire logic       passive_clamp_out,
  input wire logic       sense_amplifier_on_out,
  input wire logic       pumps_on_out,
  input wire logic [2:0] mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire cf = mode_out == `MODE_CONFIG;
  wire lk = mode_out == `MODE_LOCK;
  // five cycles cover the two-stage sync, the mode register and the output register
  property p_sleep; (!inhibit_n_in || battery_below_3v_in)[*5] |->
    mode_out == `MODE_SLEEP && passive_clamp_out && !sense_amplifier_on_out; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs");
  property p_pins; cf || lk |-> !error_n_out && !outputs_enable_out; endproperty
  a_pins: assert property (p_pins) else $error("config pins");
  property p_entry; $rose(cf) && $past(mode_out) == `MODE_IDLE |-> spi_cs_n_in; endproperty
  a_entry: assert property (p_entry) else $error("config entry");
  property p_lkfrom; $rose(lk) |-> $past(cf); endproperty
  a_lkfrom: assert property (p_lkfrom) else $error("lock entry");
  property p_lkstay; lk |=> lk || mode_out == `MODE_SLEEP; endproperty
  a_lkstay: assert property (p_lkstay) else $error("lock exit");
  // safe-off and error fall back to normal on their own; every other way needs config
  property p_nrm; $rose(mode_out == `MODE_NORMAL) && $past(mode_out) != `MODE_SAFE_OFF &&
    $past(mode_out) != `MODE_ERROR |-> $past(cf); endproperty
  a_nrm: assert property (p_nrm) else $error("normal entry");
  property p_safe; (mode_out == `MODE_SAFE_OFF && $stable(fault_in))[*4] |->
    error_n_out == !fault_in; endproperty
  a_safe: assert property (p_safe) else $error("safe-off error pin");
  property p_pump; (mode_out == `MODE_REDUCED && battery_reduced_in)[*4] |-> !pumps_on_out;
  endproperty
  a_pump: assert property (p_pump) else $error("pumps on");
  c_lock: cover property (lk);
  c_nrm: cover property (mode_out == `MODE_NORMAL);
  c_red: cover property (mode_out == `MODE_REDUCED);
endmodule
bind gate_driver_mode_control mode_ctl_chk u_mode_ctl_chk (.*);
`default_nettype wire

/* File: test/spi_host_model.sv */
/* host model: spi master, mode 0, sck 160 ns made from the core clock
   assumes the device answers each frame in the next one */
`default_nettype none
module spi_host_model (
  input  wire logic        clk_in,
  input  wire logic        miso_in,
  input  wire logic        miso_oe_n_in,
  output var  logic        cs_n_out = 1'b1,
  output var  logic        sck_out = 1'b0,
  output var  logic        mosi_out = 1'b0,
  output var  logic [15:0] rx_out = 16'h0,
  output var  logic        ok_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  event done;
  function automatic logic [2:0] crc(input logic [12:0] d);
    logic [2:0] c;
    logic f;
    c = 3'h7;
    for (int i = 12; i >= 0; i--) begin
      f = c[2] ^ d[i];
      c = {c[1], c[0] ^ f, f};
    end
    return c;
  endfunction
  task automatic w4;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic xfer(input logic [15:0] f, input int gap);
    logic [15:0] r;
    cs_n_out = 1'b0;
    w4();
    for (int i = 15; i >= 0; i--) begin
      mosi_out = f[i];
      w4();
      // a released miso must not pass for data
      r[i] = miso_oe_n_in ? ~mosi_out : miso_in;
      sck_out = 1'b1;
      w4();
      sck_out = 1'b0;
    end
    w4();
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    rx_out = r;
    ok_out = crc(r[15:3]) === r[2:0];
    -> done;
    repeat (gap) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: test/gate_driver_mode_control_tb.sv */
/* self-checking bench for the mode supervisor
   assumes the host model drives spi and the checker is bound */
`include "mode_ctl_consts.vh"
`default_nettype none
module gate_driver_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_n_in = 0, inhibit_n_in = 1, safe_off_n_in = 1, fault_in = 0;
  logic battery_reduced_in = 0, battery_below_3v_in = 0, logic_supply_reduced_in = 0;
  logic driver_enable_in = 1;
  logic [4:0] outside_faults_in = 0;
  wire spi_cs_n_in, spi_sck_in, spi_mosi_in, spi_miso_out, spi_miso_oe_n_out, error_n_out;
  wire outputs_enable_out, passive_clamp_out, sense_amplifier_on_out, pumps_on_out, ok;
  wire [2:0] mode_out;
  wire [15:0] rx;
  logic [11:0] q[$], pv;
  bit hv;
  int num_errors, n_checks, cyc, seed = 32'hd45b;
  gate_driver_mode_control #(.CFG_TIMEOUT(32'd2000)) u_gate_driver_mode_control (.*);
  spi_host_model u_spi_host_model (.clk_in(clk_in), .miso_in(spi_miso_out),
    .miso_oe_n_in(spi_miso_oe_n_out), .cs_n_out(spi_cs_n_in), .sck_out(spi_sck_in),
    .mosi_out(spi_mosi_in), .rx_out(rx), .ok_out(ok));
  initial forever #10 clk_in = ~clk_in;
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task chk(input string n, input logic [11:0] e, input logic [11:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // k low sends a bad crc and leaves the answer unchecked
  task xf(input logic w, input logic [6:0] a, input logic [4:0] d, e, input bit k);
    logic [12:0] f;
    f = {w, a, d};
    if (hv) q.push_back(pv);
    u_spi_host_model.xfer({f, u_spi_host_model.crc(f) ^ {3{~k}}}, 70);
    pv = {a, w ? d : e};
    hv = k;
  endtask
  task automatic hold(ref logic s, input logic v);
    if (hv) xf(0, `ADDR_MODE_STAT, 0, 0, 0);
    @(negedge clk_in);
    s = v;
    repeat (20) @(negedge clk_in);
    s = ~v;
    repeat (10) @(negedge clk_in);
    hv = 0;
  endtask
  initial forever begin
    @(u_spi_host_model.done);
    if (q.size() > 0) begin
      chk("answer", q.pop_front(), rx[14:3]);
      chk("crc", 12'h1, {11'h0, ok});
    end
  end
  initial begin
    outside_faults_in = 5'($random(seed));
    repeat (4) @(negedge clk_in);
    reset_n_in = 1;
    repeat (10) @(negedge clk_in);
    xf(0, `ADDR_MODE_STAT, 0, 5'h01, 1);
    xf(0, `ADDR_OUTSIDE, 0, outside_faults_in, 1);
    xf(1, `ADDR_CFG_LAST, 5'($random(seed)), 0, 1);
    xf(0, `ADDR_MODE_STAT, 0, 5'h02, 1);
    xf(1, `ADDR_SIGNATURE, 5'h1a, 0, 1);
    xf(0, `ADDR_MODE_STAT, 0, 5'h14, 1);
    xf(0, `ADDR_MODE_STAT, 0, 0, 0);
    xf(0, `ADDR_LINK_FAULT, 0, 5'h01, 1);
    chk("drive enable", 12'h1, {11'h0, outputs_enable_out});
    fault_in = 1;
    hold(safe_off_n_in, 0);
    fault_in = 0;
    hold(safe_off_n_in, 0);
    $display("normal path done");
    hold(inhibit_n_in, 0);
    xf(1, `ADDR_CFG_LAST, 5'h0, 0, 1);
    repeat (2100) @(negedge clk_in);
    xf(0, `ADDR_MODE_STAT, 0, 5'h03, 1);
    hold(inhibit_n_in, 0);
    xf(0, `ADDR_MODE_STAT, 0, 5'h01, 1);
    $display("lock path done");
    hold(battery_reduced_in, 1);
    xf(0, `ADDR_SUPPLY_RED, 0, 5'h12, 1);
    hold(inhibit_n_in, 0);
    hold(logic_supply_reduced_in, 1);
    xf(0, `ADDR_SUPPLY_RED, 0, 5'h02, 1);
    hold(battery_below_3v_in, 1);
    $display("reduced path done");
    test_done();
  end
endmodule
`default_nettype wire
